// ===== rtl/otpic_pkg.sv
// shared constants and carriers for the otp array integrity checker
package otpic_pkg;

	// bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int REG_W  = 8;

	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_FACT_FIRST = 6'h00;
	localparam logic [5:0] IDX_FACT_LAST  = 6'h04;
	localparam logic [5:0] IDX_USER_FIRST = 6'h05;
	localparam logic [5:0] IDX_USER_LAST  = 6'h0b;
	localparam logic [5:0] IDX_STATUS     = 6'h0c;
	localparam logic [5:0] IDX_USER_EXTRA = 6'h0d;
	localparam logic [5:0] IDX_FCFG       = 6'h10;
	localparam logic [5:0] IDX_FCRC       = 6'h11;
	localparam logic [5:0] IDX_UCTL       = 6'h12;
	localparam logic [5:0] IDX_UCODE      = 6'h13;
	localparam logic [5:0] IDX_CMD        = 6'h14;
	localparam logic [5:0] IDX_EVENT      = 6'h15;
	localparam logic [5:0] IDX_MASK       = 6'h16;
	localparam int         SHADOW_N       = 14;

	// field positions
	localparam int STAT_USER_OK_BIT = 4;
	localparam int STAT_FACT_OK_BIT = 2;
	localparam int FCFG_LOCK_BIT    = 7;
	localparam int UCTL_LOCK_BIT    = 0;
	localparam int UCTL_ENABLE_BIT  = 1;
	localparam int EV_FACT_ERR_BIT  = 0;
	localparam int EV_USER_ERR_BIT  = 1;
	localparam int EV_PROG_DONE_BIT = 2;
	localparam int EV_W             = 3;

	// reset values and command codes
	localparam logic [7:0] RST_REG      = 8'h00;
	localparam logic [7:0] CMD_EXEC_NVM = 8'h01;

	// check codes
	localparam int         FACT_CRC_W = 3;
	localparam logic [2:0] FACT_POLY  = 3'h3;
	localparam logic [2:0] FACT_SEED  = 3'h7;
	localparam int         FACT_BITS  = 47;
	localparam int         USER_CODE_W = 8;
	localparam logic [7:0] USER_POLY  = 8'h07;
	localparam logic [7:0] USER_SEED  = 8'hff;
	localparam int         USER_BITS  = 64;

	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [ADDR_W-1:0] awaddr;
		logic              awvalid;
		logic [DATA_W-1:0] wdata;
		logic [3:0]        wstrb;
		logic              wvalid;
		logic              bready;
		logic [ADDR_W-1:0] araddr;
		logic              arvalid;
		logic              rready;
	} otpic_axil_req_t;

	typedef struct packed {
		logic              awready;
		logic              wready;
		logic [1:0]        bresp;
		logic              bvalid;
		logic              arready;
		logic [DATA_W-1:0] rdata;
		logic [1:0]        rresp;
		logic              rvalid;
	} otpic_axil_rsp_t;

endpackage : otpic_pkg

// ===== rtl/otpic_top.sv
// otp array integrity checker: serial crc scanners plus axi4-lite register file
// Functional notes
// - The factory array is guarded by a three-bit crc stored alongside it.
// - The factory check runs on status only while the factory lock is set.
// - The factory crc uses x^3+x+1 and starts every pass from all ones.
// - Passes repeat over registers 0 to 4 and the factory config bits, lock bit left out.
// - Bits enter lsb first per register, registers in rising address order.
// - A factory remainder unequal to the stored value clears the factory ok flag.
// - Both checks read the shadow copies of the fuses, never the fuses.
// - The user array is checked on its own, only while the user lock is set.
// - An execute-programming command with the user lock set stores the user code and enables it.
// - User passes repeat over registers 5 to 11 and 13, user lock bit left out.
// - A user code unequal to the stored code clears the user ok flag.
// - Both flags are active low errors, read one when clean, and stay cleared until reset or until their check is disabled.
// - The read-only status register sits at index 12, user flag bit 4, factory flag bit 2.
`timescale 1ns/100ps
`default_nettype none

module otpic_scan #(
	parameter int         N    = 8,
	parameter int         W    = 3,
	parameter logic [W-1:0] POLY = '0,
	parameter logic [W-1:0] SEED = '1
) (
	// clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         ce,
	// data in shift order and stored code
	input  wire logic [N-1:0] data,
	input  wire logic [W-1:0] stored,
	// pass result
	output logic              pass_done,
	output logic              mismatch,
	output logic [W-1:0]      code
);
	localparam int IW = (N > 1) ? $clog2(N) : 1;
	localparam logic [IW-1:0] LAST = IW'(N - 1);

	logic [IW-1:0] bit_idx;
	logic [W-1:0]  crc;
	logic [W-1:0]  next_crc;
	logic          fb;

	always_comb begin
		fb       = crc[W-1] ^ data[bit_idx];
		next_crc = {crc[W-2:0], 1'b0} ^ (fb ? POLY : '0);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bit_idx <= '0;
			crc     <= SEED;
		end else if (ce) begin
			if (bit_idx == LAST) begin
				bit_idx <= '0;
				crc     <= SEED;
			end else begin
				bit_idx <= bit_idx + 1'b1;
				crc     <= next_crc;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pass_done <= 1'b0;
			mismatch  <= 1'b0;
			code      <= SEED;
		end else if (ce) begin
			pass_done <= (bit_idx == LAST);
			if (bit_idx == LAST) begin
				code     <= next_crc;
				mismatch <= (next_crc != stored);
			end
		end
	end
endmodule : otpic_scan

module otpic_top (
	// clock, reset, enable
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire logic                    ce,
	// axi4-lite slave
	input  wire otpic_pkg::otpic_axil_req_t axi_req,
	output otpic_pkg::otpic_axil_rsp_t      axi_rsp,
	// interrupt and flags
	output logic                         irq,
	output logic                         factory_integrity_ok_flag,
	output logic                         user_integrity_ok_flag
);
	logic [otpic_pkg::REG_W-1:0] shadow [otpic_pkg::SHADOW_N];
	logic [otpic_pkg::REG_W-1:0] fcfg;
	logic [otpic_pkg::FACT_CRC_W-1:0] fcrc;
	logic [otpic_pkg::REG_W-1:0] uctl;
	logic [otpic_pkg::USER_CODE_W-1:0] ucode;
	logic [otpic_pkg::EV_W-1:0] events;
	logic [otpic_pkg::EV_W-1:0] mask;
	logic                        prog_pending;

	// bus state
	logic                         aw_held;
	logic                         w_held;
	logic [otpic_pkg::ADDR_W-1:0] aw_addr;
	logic [otpic_pkg::DATA_W-1:0] w_data;
	logic [3:0]                   w_strb;
	logic                         bvalid;
	logic [1:0]                   bresp;
	logic                         rvalid;
	logic [1:0]                   rresp;
	logic [otpic_pkg::DATA_W-1:0] rdata;

	logic       aw_take;
	logic       w_take;
	logic       ar_take;
	logic       wr_fire;
	logic [5:0] wr_idx;
	logic [5:0] rd_idx;
	logic       wr_byte;
	logic       wr_ok;
	logic       rd_ok;
	logic [otpic_pkg::REG_W-1:0] rd_val;
	logic       rd_event;

	// check results
	logic                                f_done;
	logic                                f_mis;
	logic                                u_done;
	logic                                u_mis;
	logic [otpic_pkg::USER_CODE_W-1:0]   u_code;
	logic [otpic_pkg::FACT_BITS-1:0]     f_data;
	logic [otpic_pkg::USER_BITS-1:0]     u_data;
	logic                                f_lock;
	logic                                u_lock;
	logic                                u_enabled;
	logic [otpic_pkg::EV_W-1:0]          ev_set;
	logic [otpic_pkg::REG_W-1:0]         status;

	// shift order: bit 0 of register 0 first, config bits last
	assign f_data = {fcfg[otpic_pkg::FCFG_LOCK_BIT-1:0], shadow[4], shadow[3],
		shadow[2], shadow[1], shadow[0]};
	assign u_data = {shadow[13], shadow[11], shadow[10], shadow[9], shadow[8],
		shadow[7], shadow[6], shadow[5]};
	assign f_lock    = fcfg[otpic_pkg::FCFG_LOCK_BIT];
	assign u_lock    = uctl[otpic_pkg::UCTL_LOCK_BIT];
	assign u_enabled = u_lock && uctl[otpic_pkg::UCTL_ENABLE_BIT];

	otpic_scan #(
		.N    (otpic_pkg::FACT_BITS),
		.W    (otpic_pkg::FACT_CRC_W),
		.POLY (otpic_pkg::FACT_POLY),
		.SEED (otpic_pkg::FACT_SEED)
	) u_fact_scan (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.ce        (ce),
		.data      (f_data),
		.stored    (fcrc),
		.pass_done (f_done),
		.mismatch  (f_mis),
		.code      ()
	);

	// the user scanner runs even while disabled so a program command has a code ready
	otpic_scan #(
		.N    (otpic_pkg::USER_BITS),
		.W    (otpic_pkg::USER_CODE_W),
		.POLY (otpic_pkg::USER_POLY),
		.SEED (otpic_pkg::USER_SEED)
	) u_user_scan (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.ce        (ce),
		.data      (u_data),
		.stored    (ucode),
		.pass_done (u_done),
		.mismatch  (u_mis),
		.code      (u_code)
	);

	// integrity flags
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			factory_integrity_ok_flag <= 1'b1;
		end else if (ce) begin
			if (!f_lock) begin
				factory_integrity_ok_flag <= 1'b1;
			end else if (f_done && f_mis) begin
				factory_integrity_ok_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			user_integrity_ok_flag <= 1'b1;
		end else if (ce) begin
			if (!u_enabled) begin
				user_integrity_ok_flag <= 1'b1;
			end else if (u_done && u_mis) begin
				user_integrity_ok_flag <= 1'b0;
			end
		end
	end

	always_comb begin
		status = '0;
		status[otpic_pkg::STAT_USER_OK_BIT] = user_integrity_ok_flag;
		status[otpic_pkg::STAT_FACT_OK_BIT] = factory_integrity_ok_flag;
	end

	// axi handshakes; one write and one read in flight
	assign aw_take = ce && axi_req.awvalid && !aw_held;
	assign w_take  = ce && axi_req.wvalid && !w_held;
	assign ar_take = ce && axi_req.arvalid && !rvalid;
	assign wr_fire = ce && aw_held && w_held && !bvalid;
	assign wr_idx  = aw_addr[7:2];
	assign rd_idx  = axi_req.araddr[7:2];
	assign wr_byte = wr_fire && wr_ok && w_strb[0];

	always_comb begin
		axi_rsp         = '0;
		axi_rsp.awready = ce && !aw_held;
		axi_rsp.wready  = ce && !w_held;
		axi_rsp.bvalid  = bvalid;
		axi_rsp.bresp   = bresp;
		axi_rsp.arready = ce && !rvalid;
		axi_rsp.rvalid  = rvalid;
		axi_rsp.rresp   = rresp;
		axi_rsp.rdata   = rdata;
	end

	// status and stored code are read-only; writes there answer okay and do nothing
	always_comb begin
		wr_ok = (wr_idx <= otpic_pkg::IDX_USER_EXTRA) ||
			(wr_idx >= otpic_pkg::IDX_FCFG && wr_idx <= otpic_pkg::IDX_MASK);
		wr_ok = wr_ok && (aw_addr[1:0] == 2'h0);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= '0;
			w_data  <= '0;
			w_strb  <= '0;
		end else if (ce) begin
			if (aw_take) begin
				aw_held <= 1'b1;
				aw_addr <= axi_req.awaddr;
			end else if (wr_fire) begin
				aw_held <= 1'b0;
			end
			if (w_take) begin
				w_held <= 1'b1;
				w_data <= axi_req.wdata;
				w_strb <= axi_req.wstrb;
			end else if (wr_fire) begin
				w_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= otpic_pkg::RESP_OKAY;
		end else if (ce) begin
			if (wr_fire) begin
				bvalid <= 1'b1;
				bresp  <= wr_ok ? otpic_pkg::RESP_OKAY : otpic_pkg::RESP_SLVERR;
			end else if (bvalid && axi_req.bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// shadow copies of the fuse array
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < otpic_pkg::SHADOW_N; i++) begin
				shadow[i] <= otpic_pkg::RST_REG;
			end
		end else if (ce && wr_byte && wr_idx <= otpic_pkg::IDX_USER_EXTRA &&
			wr_idx != otpic_pkg::IDX_STATUS) begin
			shadow[wr_idx[3:0]] <= w_data[otpic_pkg::REG_W-1:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fcfg <= otpic_pkg::RST_REG;
			fcrc <= '0;
			mask <= '0;
		end else if (ce && wr_byte) begin
			if (wr_idx == otpic_pkg::IDX_FCFG) begin
				fcfg <= w_data[otpic_pkg::REG_W-1:0];
			end
			if (wr_idx == otpic_pkg::IDX_FCRC) begin
				fcrc <= w_data[otpic_pkg::FACT_CRC_W-1:0];
			end
			if (wr_idx == otpic_pkg::IDX_MASK) begin
				mask <= w_data[otpic_pkg::EV_W-1:0];
			end
		end
	end

	// user lock, program command and stored user code
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			uctl         <= otpic_pkg::RST_REG;
			ucode        <= '0;
			prog_pending <= 1'b0;
		end else if (ce) begin
			if (wr_byte && wr_idx == otpic_pkg::IDX_UCTL) begin
				uctl[otpic_pkg::UCTL_LOCK_BIT] <= w_data[otpic_pkg::UCTL_LOCK_BIT];
				if (!w_data[otpic_pkg::UCTL_LOCK_BIT]) begin
					uctl[otpic_pkg::UCTL_ENABLE_BIT] <= 1'b0;
				end
			end
			if (wr_byte && wr_idx == otpic_pkg::IDX_CMD &&
				w_data[otpic_pkg::REG_W-1:0] == otpic_pkg::CMD_EXEC_NVM && u_lock) begin
				prog_pending <= 1'b1;
			end else if (prog_pending && u_done) begin
				// wait for a whole pass so the stored code covers every bit
				prog_pending                     <= 1'b0;
				ucode                            <= u_code;
				uctl[otpic_pkg::UCTL_ENABLE_BIT] <= u_lock;
			end
		end
	end

	// events: set wins over read clear
	always_comb begin
		ev_set = '0;
		ev_set[otpic_pkg::EV_FACT_ERR_BIT]  = f_lock && f_done && f_mis;
		ev_set[otpic_pkg::EV_USER_ERR_BIT]  = u_enabled && u_done && u_mis;
		ev_set[otpic_pkg::EV_PROG_DONE_BIT] = prog_pending && u_done;
	end

	assign rd_event = ar_take && axi_req.araddr[1:0] == 2'h0 &&
		rd_idx == otpic_pkg::IDX_EVENT;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			events <= '0;
		end else if (ce) begin
			events <= (rd_event ? '0 : events) | ev_set;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else if (ce) begin
			irq <= |(events & mask);
		end
	end

	// read decode
	always_comb begin
		rd_val = '0;
		rd_ok  = axi_req.araddr[1:0] == 2'h0;
		if (rd_idx == otpic_pkg::IDX_STATUS) begin
			rd_val = status;
		end else if (rd_idx <= otpic_pkg::IDX_USER_EXTRA) begin
			rd_val = shadow[rd_idx[3:0]];
		end else begin
			unique case (rd_idx)
				otpic_pkg::IDX_FCFG:  rd_val = fcfg;
				otpic_pkg::IDX_FCRC:  rd_val = {5'h00, fcrc};
				otpic_pkg::IDX_UCTL:  rd_val = uctl;
				otpic_pkg::IDX_UCODE: rd_val = ucode;
				otpic_pkg::IDX_CMD:   rd_val = otpic_pkg::RST_REG;
				otpic_pkg::IDX_EVENT: rd_val = {5'h00, events};
				otpic_pkg::IDX_MASK:  rd_val = {5'h00, mask};
				default:              rd_ok  = 1'b0;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rresp  <= otpic_pkg::RESP_OKAY;
			rdata  <= '0;
		end else if (ce) begin
			if (ar_take) begin
				rvalid <= 1'b1;
				rresp  <= rd_ok ? otpic_pkg::RESP_OKAY : otpic_pkg::RESP_SLVERR;
				rdata  <= rd_ok ? {24'h000000, rd_val} : 32'h00000000;
			end else if (rvalid && axi_req.rready) begin
				rvalid <= 1'b0;
			end
		end
	end

endmodule : otpic_top

`default_nettype wire

// ===== verification/otpic_props.sv
// port-level assertions for the otp integrity checker
`timescale 1ns/100ps
`default_nettype none
module otpic_props (
	// clock and reset
	input wire logic                       aclk,
	input wire logic                       aresetn,
	input wire logic                       ce,
	// register bus
	input wire otpic_pkg::otpic_axil_req_t axi_req,
	input wire otpic_pkg::otpic_axil_rsp_t axi_rsp,
	// interrupt and flags
	input wire logic                       irq,
	input wire logic                       factory_integrity_ok_flag,
	input wire logic                       user_integrity_ok_flag
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic [3:0] since_w;

	// a flag may only go back high just after a write that disabled its check
	always_ff @(posedge aclk) begin
		if (!aresetn || (axi_req.wvalid && axi_rsp.wready)) begin
			since_w <= 4'h0;
		end else if (since_w != 4'hf) begin
			since_w <= since_w + 4'h1;
		end
	end

	chk_flags_reset: assert property ($rose(aresetn) |-> factory_integrity_ok_flag && user_integrity_ok_flag)
		else $error("flags not clean after reset");
	chk_idle_disabled: assert property ($rose(aresetn) |-> (factory_integrity_ok_flag && user_integrity_ok_flag) [*8])
		else $error("flag fell while checks disabled");
	chk_fact_sticky: assert property ($rose(factory_integrity_ok_flag) |-> since_w < 4'h6)
		else $error("factory flag recovered without reset or disable");
	chk_user_sticky: assert property ($rose(user_integrity_ok_flag) |-> since_w < 4'h6)
		else $error("user flag recovered without reset or disable");
	chk_bresp_hold: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
		else $error("write response dropped early");
	chk_rdata_hold: assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
		else $error("read data dropped early");
	chk_read_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
		else $error("read answer late");
	// the write fires one edge after both halves are taken; bvalid is seen one edge later
	chk_write_answer: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
		|=> ##1 axi_rsp.bvalid) else $error("write answer late");
	chk_ce_stall: assert property (!ce |-> !(axi_rsp.awready || axi_rsp.wready || axi_rsp.arready))
		else $error("ready while clock enable low");
	chk_ar_blocked: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
		else $error("address taken while read pending");

	cover property ($fell(factory_integrity_ok_flag));
	cover property ($fell(user_integrity_ok_flag));
	cover property ($rose(irq));
	cover property (axi_rsp.rvalid && axi_rsp.rresp == otpic_pkg::RESP_SLVERR);
endmodule : otpic_props
`default_nettype wire

// ===== verification/tb_otp_array_integrity_check.sv
// self-checking bench for the otp integrity checker
`timescale 1ns/100ps
`default_nettype none
module tb_otp_array_integrity_check;
	logic                       aclk;
	logic                       aresetn;
	logic                       ce;
	otpic_pkg::otpic_axil_req_t req;
	otpic_pkg::otpic_axil_rsp_t rsp;
	logic                       irq;
	logic                       f_ok;
	logic                       u_ok;
	int                         n_errors;
	int                         n_checks;
	integer                     seed;
	logic [7:0]                 d;
	logic [7:0]                 good;
	logic [1:0]                 r;
	logic [7:0]                 sh [0:13];
	logic [6:0]                 fcfgv;

	otpic_top DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce), .axi_req(req), .axi_rsp(rsp),
		.irq(irq), .factory_integrity_ok_flag(f_ok), .user_integrity_ok_flag(u_ok));

	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	task automatic note(input string what, input logic bad);
		n_checks++;
		if (bad) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s", $time, what);
		end
	endtask : note
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
		note(what, got !== exp);
	endtask : cmp8
	task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp, input string what);
		note(what, got !== exp);
	endtask : cmp_resp
	task automatic cmp_bit(input logic got, input logic exp, input string what);
		note(what, got !== exp);
	endtask : cmp_bit

	// response ready starts at random and is raised on the next edge, before the response arrives
	task automatic wr(input logic [5:0] idx, input logic [7:0] v, output logic [1:0] resp);
		int n;
		n = 0;
		@(posedge aclk);
		req.awaddr <= {idx, 2'h0};
		req.awvalid <= 1'b1;
		req.wdata <= {24'h0, v};
		req.wstrb <= 4'hf;
		req.wvalid <= 1'b1;
		req.bready <= 1'($random(seed));
		while (n < 60) begin
			@(posedge aclk);
			n++;
			if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
			if (req.bready && rsp.bvalid) begin
				resp = rsp.bresp;
				req.bready <= 1'b0;
				n = 99;
			end else req.bready <= 1'b1;
		end
		if (n != 99) note("write hang", 1'b1);
	endtask : wr

	task automatic rd(input logic [5:0] idx, output logic [7:0] v, output logic [1:0] resp);
		int n;
		n = 0;
		@(posedge aclk);
		req.araddr <= {idx, 2'h0};
		req.arvalid <= 1'b1;
		req.rready <= 1'($random(seed));
		while (n < 60) begin
			@(posedge aclk);
			n++;
			if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
			if (req.rready && rsp.rvalid) begin
				v = rsp.rdata[7:0];
				resp = rsp.rresp;
				req.rready <= 1'b0;
				n = 99;
			end else req.rready <= 1'b1;
		end
		if (n != 99) note("read hang", 1'b1);
	endtask : rd

	task automatic do_reset;
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
	endtask : do_reset

	task automatic wait_low(input bit user, input int lim);
		repeat (lim) begin
			@(posedge aclk);
			if ((user ? u_ok : f_ok) === 1'b0) break;
		end
	endtask : wait_low

	// serial crc, msb feedback, bit 0 of v enters first
	function automatic logic [7:0] crc_calc(input logic [63:0] v, input int n, input int w,
		input logic [7:0] poly, input logic [7:0] sd);
		logic [7:0] c;
		logic       fb;
		c = sd;
		for (int i = 0; i < n; i++) begin
			fb = c[w-1] ^ v[i];
			c = (c << 1) ^ (fb ? poly : 8'h00);
		end
		return c & ((8'h01 << w) - 8'h01);
	endfunction : crc_calc

	task automatic complete_run;
		$display("checks %0d, mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : complete_run

	initial begin
		repeat (20000) @(posedge aclk);
		n_errors++;
		complete_run();
	end

	initial begin
		aresetn = 1'b0;
		ce = 1'b1;
		req = '0;
		seed = 32'hf0a0e567;
		n_errors = 0;
		n_checks = 0;
		do_reset();
		rd(otpic_pkg::IDX_STATUS, d, r);
		cmp8(d, 8'h14, "status after reset");
		wr(otpic_pkg::IDX_STATUS, 8'hff, r);
		rd(otpic_pkg::IDX_STATUS, d, r);
		cmp8(d, 8'h14, "status is read-only");
		rd(6'h20, d, r);
		cmp_resp(r, otpic_pkg::RESP_SLVERR, "unmapped read");
		@(posedge aclk);
		ce <= 1'b0;
		repeat (3) @(posedge aclk);
		ce <= 1'b1;
		$display("test reset_map done");
		// random contents, then all ones as the corner case
		for (int t = 0; t < 3; t++) begin
			wr(otpic_pkg::IDX_FCFG, 8'h00, r);
			for (int i = 0; i < 5; i++) begin
				sh[i] = (t == 2) ? 8'hff : 8'($random(seed));
				wr(6'(i), sh[i], r);
			end
			fcfgv = (t == 2) ? 7'h7f : 7'($random(seed));
			good = crc_calc({17'h0, fcfgv, sh[4], sh[3], sh[2], sh[1], sh[0]}, 47, 3, 8'h03, 8'h07);
			wr(otpic_pkg::IDX_FCRC, good, r);
			// config bits first, then drain any pass that straddled the writes before locking
			wr(otpic_pkg::IDX_FCFG, {1'b0, fcfgv}, r);
			repeat (50) @(posedge aclk);
			wr(otpic_pkg::IDX_FCFG, {1'b1, fcfgv}, r);
			wait_low(0, 150);
			cmp_bit(f_ok, 1'b1, "factory crc match");
		end
		$display("test factory_good done");
		wr(otpic_pkg::IDX_FCFG, {1'b0, fcfgv}, r);
		wr(otpic_pkg::IDX_MASK, 8'h07, r);
		wr(6'h00, sh[0] ^ 8'h01, r);
		wait_low(0, 150);
		cmp_bit(f_ok, 1'b1, "factory check while unlocked");
		wr(otpic_pkg::IDX_FCFG, {1'b1, fcfgv}, r);
		wait_low(0, 150);
		cmp_bit(f_ok, 1'b0, "factory mismatch");
		repeat (3) @(posedge aclk);
		cmp_bit(irq, 1'b1, "interrupt raised");
		rd(otpic_pkg::IDX_EVENT, d, r);
		cmp8(d & 8'h01, 8'h01, "factory event");
		rd(otpic_pkg::IDX_STATUS, d, r);
		cmp8(d, 8'h10, "status factory error");
		wr(6'h00, sh[0], r);
		repeat (150) @(posedge aclk);
		cmp_bit(f_ok, 1'b0, "factory flag sticky");
		wr(otpic_pkg::IDX_MASK, 8'h00, r);
		repeat (3) @(posedge aclk);
		cmp_bit(irq, 1'b0, "interrupt masked");
		wr(otpic_pkg::IDX_FCFG, {1'b0, fcfgv}, r);
		repeat (3) @(posedge aclk);
		cmp_bit(f_ok, 1'b1, "disabled check clean");
		do_reset();
		$display("test factory_error done");
		for (int i = 5; i < 14; i++) begin
			sh[i] = 8'($random(seed));
			if (i != 12) wr(6'(i), sh[i], r);
		end
		wr(otpic_pkg::IDX_CMD, otpic_pkg::CMD_EXEC_NVM, r);
		repeat (150) @(posedge aclk);
		rd(otpic_pkg::IDX_UCTL, d, r);
		cmp8(d, 8'h00, "program without lock");
		wr(otpic_pkg::IDX_UCTL, 8'h01, r);
		wr(otpic_pkg::IDX_CMD, otpic_pkg::CMD_EXEC_NVM, r);
		repeat (150) @(posedge aclk);
		rd(otpic_pkg::IDX_UCTL, d, r);
		cmp8(d, 8'h03, "program enables check");
		good = crc_calc({sh[13], sh[11], sh[10], sh[9], sh[8], sh[7], sh[6], sh[5]}, 64, 8,
			otpic_pkg::USER_POLY, otpic_pkg::USER_SEED);
		rd(otpic_pkg::IDX_UCODE, d, r);
		cmp8(d, good, "stored user code");
		rd(otpic_pkg::IDX_EVENT, d, r);
		cmp8(d & 8'h04, 8'h04, "program done event");
		wait_low(1, 200);
		cmp_bit(u_ok, 1'b1, "user code match");
		wr(otpic_pkg::IDX_USER_EXTRA, sh[13] ^ 8'h80, r);
		wait_low(1, 150);
		cmp_bit(u_ok, 1'b0, "user mismatch");
		cmp_bit(f_ok, 1'b1, "factory unaffected");
		rd(otpic_pkg::IDX_STATUS, d, r);
		cmp8(d, 8'h04, "status user error");
		rd(otpic_pkg::IDX_EVENT, d, r);
		cmp8(d & 8'h02, 8'h02, "user event");
		$display("test user_check done");
		complete_run();
	end
endmodule : tb_otp_array_integrity_check

bind otpic_top otpic_props CHK (.aclk(aclk), .aresetn(aresetn), .ce(ce), .axi_req(axi_req),
	.axi_rsp(axi_rsp), .irq(irq), .factory_integrity_ok_flag(factory_integrity_ok_flag),
	.user_integrity_ok_flag(user_integrity_ok_flag));
`default_nettype wire
